// File: fxe_exception_reg.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Reserved bits, upper half and bits between the carry and the low field, always read back as zero.
// - Summary sets whenever excess becomes one, except software writing summary zero.
// - Summary changes only at completion, software write or restore, never at execution.
// - Summary is unrenamed: one committed and one checkpoint copy per thread.
// - Excess flag written by pipes with recording enabled and by software.
// - Carry flag written by carrying and algebraic-shift ops and by software.
// - Renamed fields held in the architected file, one set per thread.
// - The architected file also holds one checkpoint copy per thread.
// - Results from flushed paths are discarded before commit.
module fxe_exception_reg
  import fxe_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Execution pipe flag results, one lane per pipe
  input wire logic [FXE_PIPES-1:0] ex_valid,
  input wire logic [FXE_PIPES*FXE_TID_W-1:0] ex_thread,
  input wire logic [FXE_PIPES-1:0] ex_ov_en,
  input wire logic [FXE_PIPES-1:0] ex_ov,
  input wire logic [FXE_PIPES-1:0] ex_ca_en,
  input wire logic [FXE_PIPES-1:0] ex_ca,
  // Completion and flush
  input wire logic cmp_valid,
  input wire logic [FXE_TID_W-1:0] cmp_thread,
  input wire logic flush_valid,
  input wire logic [FXE_TID_W-1:0] flush_thread,
  // Software move-to
  input wire logic mt_valid,
  input wire logic [FXE_TID_W-1:0] mt_thread,
  input wire logic [FXE_REG_W-1:0] mt_data,
  // Software move-from
  input wire logic mf_valid,
  input wire logic [FXE_TID_W-1:0] mf_thread,
  output logic mf_rvalid,
  output logic [FXE_REG_W-1:0] mf_rdata,
  // Transactional memory control
  input wire logic tm_begin,
  input wire logic tm_fail,
  input wire logic [FXE_TID_W-1:0] tm_thread
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [FXE_THREADS-1:0] pend_ov_en;
    logic [FXE_THREADS-1:0] pend_ov;
    logic [FXE_THREADS-1:0] pend_ca_en;
    logic [FXE_THREADS-1:0] pend_ca;
    logic rvalid;
    logic [FXE_REG_W-1:0] rdata;
  } fxe_top_type;

  fxe_top_type st_ff;
  fxe_top_type nxt_st;

  logic [FXE_THREADS-1:0] w_so;
  logic [FXE_THREADS-1:0] w_ov;
  logic [FXE_THREADS-1:0] w_ca;
  logic [FXE_HI_W-1:0] w_hi [FXE_THREADS];

  // ***************************************************************
  // Per-thread committed state
  // ***************************************************************
  genvar gt;
  generate
    for (gt = 0; gt < FXE_THREADS; gt++) begin : g_thr
      logic sel_cmp;
      logic sel_mt;
      logic sel_tm;
      assign sel_cmp = cmp_valid && (cmp_thread == FXE_TID_W'(gt));
      assign sel_mt = mt_valid && (mt_thread == FXE_TID_W'(gt));
      assign sel_tm = tm_thread == FXE_TID_W'(gt);
      fxe_thread_slot u_slot (
        .clock(clock),
        .srst(srst),
        .commit(sel_cmp),
        .c_ov_en(st_ff.pend_ov_en[gt]),
        .c_ov(st_ff.pend_ov[gt]),
        .c_ca_en(st_ff.pend_ca_en[gt]),
        .c_ca(st_ff.pend_ca[gt]),
        .mt_wr(sel_mt),
        .mt_so(mt_data[FXE_SO_POS]),
        .mt_ov(mt_data[FXE_OV_POS]),
        .mt_ca(mt_data[FXE_CA_POS]),
        .mt_hi(mt_data[FXE_HI_MSB:FXE_HI_LSB]),
        .ckpt(tm_begin && sel_tm),
        .restore(tm_fail && sel_tm),
        .so(w_so[gt]),
        .ov(w_ov[gt]),
        .ca(w_ca[gt]),
        .hi(w_hi[gt])
      );
    end
  endgenerate

  // ***************************************************************
  // Speculative staging, commit and read
  // ***************************************************************
  always_comb begin
    logic [FXE_TID_W-1:0] tid;
    tid = '0;
    nxt_st = st_ff;
    // Completion consumes staged results of its thread.
    if (cmp_valid) begin
      nxt_st.pend_ov_en[cmp_thread] = 1'b0;
      nxt_st.pend_ca_en[cmp_thread] = 1'b0;
    end
    // New execution results are staged; higher pipe wins within a thread.
    for (int p = 0; p < FXE_PIPES; p++) begin
      tid = ex_thread[p*FXE_TID_W +: FXE_TID_W];
      if (ex_valid[p] && ex_ov_en[p]) begin
        nxt_st.pend_ov_en[tid] = 1'b1;
        nxt_st.pend_ov[tid] = ex_ov[p];
      end
      if (ex_valid[p] && ex_ca_en[p]) begin
        nxt_st.pend_ca_en[tid] = 1'b1;
        nxt_st.pend_ca[tid] = ex_ca[p];
      end
    end
    // A flush drops everything staged for that thread, including this cycle's.
    if (flush_valid) begin
      nxt_st.pend_ov_en[flush_thread] = 1'b0;
      nxt_st.pend_ca_en[flush_thread] = 1'b0;
    end
    nxt_st.rvalid = mf_valid;
    nxt_st.rdata = {FXE_UPPER_ZERO, w_so[mf_thread], w_ov[mf_thread], w_ca[mf_thread],
                    FXE_MID_ZERO, w_hi[mf_thread]};
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign mf_rvalid = st_ff.rvalid;
  assign mf_rdata = st_ff.rdata;

  // ***************************************************************
  // Checks
  // ***************************************************************
  property p_rsv_zero;
    @(posedge clock) disable iff (srst)
      mf_rvalid |-> (mf_rdata[FXE_REG_W-1:FXE_SO_POS+1] == FXE_UPPER_ZERO)
                 && (mf_rdata[FXE_RSV_MID_MSB:FXE_RSV_MID_LSB] == FXE_MID_ZERO)
                 && ((mf_rdata[FXE_HI_MSB:FXE_HI_LSB] & ~FXE_HI_MASK) == FXE_HI_RST);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");

  property p_so_sets;
    @(posedge clock) disable iff (srst)
      (cmp_valid && !mt_valid && !tm_fail && st_ff.pend_ov_en[0] && st_ff.pend_ov[0]
       && cmp_thread == 2'h0) |=> w_so[0] && w_ov[0];
  endproperty
  a_so_sets: assert property (p_so_sets) else $error("summary not set by excess");

  property p_mt_so_zero;
    @(posedge clock) disable iff (srst)
      (mt_valid && mt_thread == 2'h0 && !tm_fail && !mt_data[FXE_SO_POS] && mt_data[FXE_OV_POS])
      |=> !w_so[0] && w_ov[0];
  endproperty
  a_mt_so_zero: assert property (p_mt_so_zero) else $error("write of summary zero not kept");

  property p_no_spec;
    @(posedge clock) disable iff (srst)
      (!cmp_valid && !mt_valid && !tm_fail) |=> $stable(w_so) && $stable(w_ov) && $stable(w_ca);
  endproperty
  a_no_spec: assert property (p_no_spec) else $error("flags changed without completion");

  property p_ca_commit;
    @(posedge clock) disable iff (srst)
      (cmp_valid && cmp_thread == 2'h1 && !mt_valid && !tm_fail && st_ff.pend_ca_en[1])
      |=> w_ca[1] == $past(st_ff.pend_ca[1]);
  endproperty
  a_ca_commit: assert property (p_ca_commit) else $error("carry not committed");

  property p_mf_read;
    @(posedge clock) disable iff (srst)
      (mf_valid && mf_thread == 2'h3 && !cmp_valid && !mt_valid && !tm_fail)
      |=> mf_rvalid && mf_rdata[FXE_OV_POS] == w_ov[3] && mf_rdata[FXE_SO_POS] == w_so[3];
  endproperty
  a_mf_read: assert property (p_mf_read) else $error("read does not show flags");

  property p_flush_drop;
    @(posedge clock) disable iff (srst)
      (flush_valid && flush_thread == 2'h2) |=> !st_ff.pend_ov_en[2] && !st_ff.pend_ca_en[2];
  endproperty
  a_flush_drop: assert property (p_flush_drop) else $error("flushed result survived");

  property p_stage_keep;
    @(posedge clock) disable iff (srst)
      (ex_valid[1] && ex_ov_en[1] && ex_thread[3:2] == 2'h2 && !(ex_valid[2] && ex_ov_en[2])
       && !(ex_valid[3] && ex_ov_en[3]) && !(flush_valid && flush_thread == 2'h2))
      |=> st_ff.pend_ov_en[2] && st_ff.pend_ov[2] == $past(ex_ov[1]);
  endproperty
  a_stage_keep: assert property (p_stage_keep) else $error("excess result not staged");

endmodule : fxe_exception_reg

`default_nettype wire

// File: fxe_pkg.sv
package fxe_pkg;

  // ***************************************************************
  // Geometry
  // ***************************************************************
  // Bit numbers count from the least significant end (bit 0 is the LSB).
  localparam int unsigned FXE_THREADS = 4;
  localparam int unsigned FXE_PIPES = 4;
  localparam int unsigned FXE_TID_W = 2;
  localparam int unsigned FXE_REG_W = 64;
  localparam int unsigned FXE_HI_W = 20;

  // ***************************************************************
  // Field positions (LSB-0 indices into the 64-bit word)
  // ***************************************************************
  localparam int unsigned FXE_SO_POS = 31;
  localparam int unsigned FXE_OV_POS = 30;
  localparam int unsigned FXE_CA_POS = 29;
  localparam int unsigned FXE_HI_LSB = 0;
  localparam int unsigned FXE_HI_MSB = 19;
  localparam int unsigned FXE_RSV_MID_LSB = 20;
  localparam int unsigned FXE_RSV_MID_MSB = 28;

  // ***************************************************************
  // Masks and reset values
  // ***************************************************************
  // Implemented bits of the count/compare region; the middle of it reads as zero.
  localparam logic [FXE_HI_W-1:0] FXE_HI_MASK = 20'hc007f;
  localparam logic [FXE_HI_W-1:0] FXE_HI_RST = 20'h00000;
  localparam logic [31:0] FXE_UPPER_ZERO = 32'h00000000;
  localparam logic [8:0] FXE_MID_ZERO = 9'h000;
  localparam logic [FXE_REG_W-1:0] FXE_RDATA_RST = 64'h0000000000000000;

endpackage : fxe_pkg

// File: fxe_thread_slot.sv
`timescale 1ns/1ps
`default_nettype none

// One thread's committed exception state plus its transactional checkpoint.
module fxe_thread_slot
  import fxe_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Commit of completed flag results
  input wire logic commit,
  input wire logic c_ov_en,
  input wire logic c_ov,
  input wire logic c_ca_en,
  input wire logic c_ca,
  // Software move-to write
  input wire logic mt_wr,
  input wire logic mt_so,
  input wire logic mt_ov,
  input wire logic mt_ca,
  input wire logic [FXE_HI_W-1:0] mt_hi,
  // Transactional checkpoint and restore
  input wire logic ckpt,
  input wire logic restore,
  // Working copy
  output logic so,
  output logic ov,
  output logic ca,
  output logic [FXE_HI_W-1:0] hi
);

  typedef struct packed {
    logic so;
    logic ov;
    logic ca;
    logic [FXE_HI_W-1:0] hi;
    logic ck_so;
    logic ck_ov;
    logic ck_ca;
    logic [FXE_HI_W-1:0] ck_hi;
  } fxe_slot_type;

  fxe_slot_type st_ff;
  fxe_slot_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (restore) begin
      nxt_st.so = st_ff.ck_so;
      nxt_st.ov = st_ff.ck_ov;
      nxt_st.ca = st_ff.ck_ca;
      nxt_st.hi = st_ff.ck_hi;
    end else if (mt_wr) begin
      // A software write stores summary as given, even zero with excess one.
      nxt_st.so = mt_so;
      nxt_st.ov = mt_ov;
      nxt_st.ca = mt_ca;
      nxt_st.hi = mt_hi & FXE_HI_MASK;
    end else if (commit) begin
      if (c_ov_en) begin
        nxt_st.ov = c_ov;
        nxt_st.so = st_ff.so | c_ov;
      end
      if (c_ca_en) begin
        nxt_st.ca = c_ca;
      end
    end
    if (ckpt) begin
      nxt_st.ck_so = st_ff.so;
      nxt_st.ck_ov = st_ff.ov;
      nxt_st.ck_ca = st_ff.ca;
      nxt_st.ck_hi = st_ff.hi;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign so = st_ff.so;
  assign ov = st_ff.ov;
  assign ca = st_ff.ca;
  assign hi = st_ff.hi;

  // ***************************************************************
  // Checks
  // ***************************************************************
  property p_restore_so;
    @(posedge clock) disable iff (srst)
      (restore && !ckpt) |=> (so == $past(st_ff.ck_so)) && (ov == $past(st_ff.ck_ov));
  endproperty
  a_restore_so: assert property (p_restore_so) else $error("restore did not load checkpoint");

  property p_ckpt_hold;
    @(posedge clock) disable iff (srst)
      (!ckpt) |=> $stable(st_ff.ck_so) && $stable(st_ff.ck_ca);
  endproperty
  a_ckpt_hold: assert property (p_ckpt_hold) else $error("checkpoint changed without capture");

endmodule : fxe_thread_slot

`default_nettype wire

// File: fxe_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none

// *******************************************************
// Execution pipes and completion logic seen by the register
// *******************************************************
// After each result all lanes go idle, raise their enables and show the inverse of their last flags and thread so stale data is never kind.
module fxe_pipe_model
  import fxe_pkg::*;
(
  // Clock
  input wire logic clock,
  // Execution results
  output logic [FXE_PIPES-1:0] ex_valid,
  output logic [FXE_PIPES*FXE_TID_W-1:0] ex_thread,
  output logic [FXE_PIPES-1:0] ex_ov_en,
  output logic [FXE_PIPES-1:0] ex_ov,
  output logic [FXE_PIPES-1:0] ex_ca_en,
  output logic [FXE_PIPES-1:0] ex_ca,
  // Completion and flush
  output logic cmp_valid,
  output logic [FXE_TID_W-1:0] cmp_thread,
  output logic flush_valid,
  output logic [FXE_TID_W-1:0] flush_thread
);
  initial begin
    {ex_valid, ex_thread, ex_ov_en, ex_ov, ex_ca_en, ex_ca} = '0;
    {cmp_valid, cmp_thread, flush_valid, flush_thread} = '0;
  end

  // Flags f are {ov_en, ov, ca_en, ca} for one result on pipe p.
  task automatic exec(input int p, input logic [1:0] t, input logic [3:0] f);
    @(posedge clock);
    ex_valid <= 4'h1 << p;
    ex_thread[2*p +: 2] <= t;
    ex_ov_en <= {3'h0, f[3]} << p;
    ex_ov[p] <= f[2];
    ex_ca_en <= {3'h0, f[1]} << p;
    ex_ca[p] <= f[0];
    @(posedge clock);
    ex_valid <= 4'h0;
    ex_ov_en <= 4'hf;
    ex_ca_en <= 4'hf;
    ex_ov <= ~ex_ov;
    ex_ca <= ~ex_ca;
    ex_thread <= ~ex_thread;
  endtask : exec

  // A completion when fl is low, a flush when it is high.
  task automatic pulse(input logic fl, input logic [1:0] t);
    @(posedge clock);
    cmp_valid <= ~fl;
    flush_valid <= fl;
    cmp_thread <= t;
    flush_thread <= t;
    @(posedge clock);
    cmp_valid <= 1'b0;
    flush_valid <= 1'b0;
    cmp_thread <= ~t;
    flush_thread <= ~t;
  endtask : pulse
endmodule : fxe_pipe_model

`default_nettype wire

// File: fxe_exception_reg_tb.sv
`timescale 1ns/1ps
`default_nettype none

// *******************************************************
// Register-level tests through move-to, move-from and the pipes
// *******************************************************
module fxe_exception_reg_tb;
  import fxe_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [FXE_PIPES-1:0] ex_valid, ex_ov_en, ex_ov, ex_ca_en, ex_ca;
  logic [FXE_PIPES*FXE_TID_W-1:0] ex_thread;
  logic cmp_valid, flush_valid, mf_rvalid;
  logic [1:0] cmp_thread, flush_thread;
  logic mt_valid = 1'b0, mf_valid = 1'b0, tm_begin = 1'b0, tm_fail = 1'b0;
  logic [1:0] mt_thread = 2'h0, mf_thread = 2'h0, tm_thread = 2'h0;
  logic [63:0] mt_data = 64'h0, mf_rdata;
  int num_errors = 0;
  int cmp_count = 0;

  always #5 clock = ~clock;

  fxe_pipe_model fxe_pipe_model_inst (.clock(clock), .ex_valid(ex_valid),
    .ex_thread(ex_thread), .ex_ov_en(ex_ov_en), .ex_ov(ex_ov), .ex_ca_en(ex_ca_en),
    .ex_ca(ex_ca), .cmp_valid(cmp_valid), .cmp_thread(cmp_thread),
    .flush_valid(flush_valid), .flush_thread(flush_thread));

  fxe_exception_reg fxe_exception_reg_inst (.clock(clock), .srst(srst), .ex_valid(ex_valid),
    .ex_thread(ex_thread), .ex_ov_en(ex_ov_en), .ex_ov(ex_ov), .ex_ca_en(ex_ca_en),
    .ex_ca(ex_ca), .cmp_valid(cmp_valid), .cmp_thread(cmp_thread),
    .flush_valid(flush_valid), .flush_thread(flush_thread), .mt_valid(mt_valid),
    .mt_thread(mt_thread), .mt_data(mt_data), .mf_valid(mf_valid), .mf_thread(mf_thread),
    .mf_rvalid(mf_rvalid), .mf_rdata(mf_rdata), .tm_begin(tm_begin), .tm_fail(tm_fail),
    .tm_thread(tm_thread));

  // Expected read word from {summary, excess, carry} and the low field.
  function automatic logic [63:0] word(input logic [2:0] f, input logic [19:0] hi);
    return {FXE_UPPER_ZERO, f, FXE_MID_ZERO, hi & FXE_HI_MASK};
  endfunction : word

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: read valid %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic rd(input logic [1:0] t, input logic [63:0] exp);
    @(posedge clock);
    mf_valid <= 1'b1;
    mf_thread <= t;
    @(posedge clock);
    mf_valid <= 1'b0;
    mf_thread <= ~t;
    @(negedge clock);
    chk1(mf_rvalid, 1'b1);
    chk(mf_rdata, exp);
    @(negedge clock);
    chk1(mf_rvalid, 1'b0);
  endtask : rd

  task automatic mt(input logic [1:0] t, input logic [63:0] d);
    @(posedge clock);
    mt_valid <= 1'b1;
    mt_thread <= t;
    mt_data <= d;
    @(posedge clock);
    mt_valid <= 1'b0;
    mt_thread <= ~t;
    mt_data <= ~d;
  endtask : mt

  task automatic tm(input logic fail, input logic [1:0] t);
    @(posedge clock);
    tm_begin <= ~fail;
    tm_fail <= fail;
    tm_thread <= t;
    @(posedge clock);
    tm_begin <= 1'b0;
    tm_fail <= 1'b0;
    tm_thread <= ~t;
  endtask : tm

  task automatic stop_test;
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    #20000;
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    for (int t = 0; t < 4; t++) rd(t[1:0], 64'h0);
    fxe_pipe_model_inst.exec(0, 2'h0, 4'hc);
    rd(2'h0, 64'h0);
    fxe_pipe_model_inst.pulse(1'b0, 2'h0);
    rd(2'h0, word(3'h6, 20'h0));
    fxe_pipe_model_inst.exec(2, 2'h0, 4'h8);
    fxe_pipe_model_inst.pulse(1'b0, 2'h0);
    rd(2'h0, word(3'h4, 20'h0));
    fxe_pipe_model_inst.exec(3, 2'h1, 4'h3);
    fxe_pipe_model_inst.pulse(1'b0, 2'h1);
    rd(2'h1, word(3'h1, 20'h0));
    rd(2'h0, word(3'h4, 20'h0));
    fxe_pipe_model_inst.exec(1, 2'h2, 4'hf);
    fxe_pipe_model_inst.pulse(1'b1, 2'h2);
    fxe_pipe_model_inst.pulse(1'b0, 2'h2);
    rd(2'h2, 64'h0);
    for (int t = 0; t < 4; t++) mt(t[1:0], {32'hffffffff, t[0], t[1], 10'h3ff,
      20'hfff80 | (20'h1 << t)});
    for (int t = 0; t < 4; t++) rd(t[1:0], word({t[0], t[1], 1'b1},
      20'hfff80 | (20'h1 << t)));
    mt(2'h0, word(3'h2, 20'h0));
    rd(2'h0, word(3'h2, 20'h0));
    fxe_pipe_model_inst.exec(0, 2'h0, 4'hc);
    fxe_pipe_model_inst.pulse(1'b0, 2'h0);
    rd(2'h0, word(3'h6, 20'h0));
    tm(1'b0, 2'h3);
    mt(2'h3, 64'h0);
    fxe_pipe_model_inst.exec(0, 2'h3, 4'hc);
    fxe_pipe_model_inst.pulse(1'b0, 2'h3);
    tm(1'b1, 2'h3);
    rd(2'h3, word(3'h7, 20'hfff88));
    // A flush in the same cycle as a result must drop that result as well.
    fork
      fxe_pipe_model_inst.exec(1, 2'h2, 4'ha);
      fxe_pipe_model_inst.pulse(1'b1, 2'h2);
    join
    fxe_pipe_model_inst.pulse(1'b0, 2'h2);
    rd(2'h2, word(3'h3, 20'hfff84));
    stop_test();
  end
endmodule : fxe_exception_reg_tb

`default_nettype wire
